// *** core/address_capable_io_port.sv ***
// Two 8-bit ports whose pins serve as general I/O or address outputs, with AHB-Lite registers.
//
// The AHB-Lite slave port was left to the implementer.
`timescale 1ns/1ps

// Contract
// - Modes 2, 3, 6, 7: second-port pull-up on when direction 0 and control 1.
// - Modes 1, 4, 5: second-port pull-ups always off.
// - Second-port pull-up control clears on reset and hardware standby only.
// - Modes 1, 4, 5: all second-port pins are address outputs.
// - Modes 2, 6: second-port pin is address output if direction 1, else input.
// - Modes 3, 7: second-port pin drives data register if direction 1, else input.
// - Third-port direction register is 8-bit write-only; reads return a fixed junk value.
// - Third-port direction clears on reset and hardware standby only.
// - In software standby, address pins hold level or float per hold-enable bit.
// - Modes 1, 4, 5: all third-port pins are address outputs.
// - Modes 2, 6: third-port pin is address output if direction 1, else input.
// - Modes 3, 7: third-port pin is general output if direction 1, else input.
// - Third-port data register is read/write, drives outputs, clears on reset and hardware standby.
// - Third-port pin readback register is read-only; writes are ignored.
// - Readback bit gives data bit when direction 1, pin level when 0.
// - Readback holds its value during software standby; reflects pins after clearing.
// - Third-port pull-up control is 8-bit read/write, reset to zero.
// - Third-port pull-up on in modes 2, 3, 6, 7 when direction 0 and control 1.
module address_capable_io_port (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Operating mode and standby
    input wire logic [2:0] mode_pins,
    input wire logic hw_standby,
    input wire logic sw_standby,
    // Internal address bus to be driven out
    input wire logic [acio_pkg::ADDR_BUS_W-1:0] addr_bus,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [acio_pkg::HADDR_W-1:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [acio_pkg::HDATA_W-1:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [acio_pkg::HDATA_W-1:0] hrdata,
    output logic hresp,
    // Second port pins
    input wire logic [7:0] port_b_in,
    output acio_pkg::pin_drive_t port_b_drive,
    output logic [7:0] port_b_pullup,
    // Third port pins
    input wire logic [7:0] port_c_in,
    output acio_pkg::pin_drive_t port_c_drive,
    output logic [7:0] port_c_pullup
);

    // ------------------------------------------------------------
    // Decoding helpers
    // ------------------------------------------------------------
    // True when the address is the byte address of a register index.
    function automatic logic reg_hit(
        input logic [31:0] a,
        input logic [15:0] idx
    );
        reg_hit = (a == {14'h0000, idx, 2'h0});
    endfunction

    // Pins forced to address outputs whatever the direction bits hold.
    function automatic logic mode_all_addr(input acio_pkg::op_mode_t m);
        return m inside {acio_pkg::MODE_1, acio_pkg::MODE_4, acio_pkg::MODE_5};
    endfunction

    // Direction bit selects between address output and input.
    function automatic logic mode_sel_addr(input acio_pkg::op_mode_t m);
        return m inside {acio_pkg::MODE_2, acio_pkg::MODE_6};
    endfunction

    // Mask of pins acting as address outputs.
    function automatic logic [7:0] addr_mask(input acio_pkg::op_mode_t m, input logic [7:0] dir);
        return mode_all_addr(m) ? 8'hFF : (mode_sel_addr(m) ? dir : 8'h00);
    endfunction

    // Mask of pins acting as general outputs; mode 0 behaves as single-chip.
    function automatic logic [7:0] gpo_mask(input acio_pkg::op_mode_t m, input logic [7:0] dir);
        return (mode_all_addr(m) || mode_sel_addr(m)) ? 8'h00 : dir;
    endfunction

    // Pull-ups exist only where the mode leaves the port software controlled.
    function automatic logic [7:0] pullup_calc(input acio_pkg::op_mode_t m,
        input acio_pkg::port_regs_t r);
        return mode_all_addr(m) ? 8'h00 : ~r.dir & r.pup;
    endfunction

    // Pin drive for one port, including the software standby behaviour.
    function automatic acio_pkg::pin_drive_t drive_calc(input acio_pkg::op_mode_t m,
        input acio_pkg::port_regs_t r, input logic [7:0] addr, input acio_pkg::pin_drive_t prev,
        input logic hw_stby, input logic sw_stby, input logic standby_output_hold_enable);
        logic [7:0] am;
        logic [7:0] gm;
        am = addr_mask(m, r.dir);
        gm = gpo_mask(m, r.dir);
        drive_calc.out = (am & addr) | (gm & r.data);
        drive_calc.oe = am | gm;
        if (hw_stby) begin
            drive_calc.out = 8'h00;
            drive_calc.oe = 8'h00;
        end else if (sw_stby) begin
            drive_calc.out = (am & prev.out) | (gm & r.data);
            drive_calc.oe = (standby_output_hold_enable ? am : 8'h00) | gm;
        end
    endfunction

    // Direction bit picks the data register, otherwise the live pin.
    function automatic logic [7:0] readback_calc(input acio_pkg::port_regs_t r,
        input logic [7:0] pins);
        readback_calc = (r.dir & r.data) | (~r.dir & pins);
    endfunction

    // Register write for one port; the pin readback index is not writable.
    function automatic acio_pkg::port_regs_t port_write(input acio_pkg::port_regs_t cur,
        input logic en, input logic [31:0] a, input logic [7:0] wbyte,
        input logic [15:0] idx_dir, input logic [15:0] idx_data, input logic [15:0] idx_pup);
        port_write = cur;
        if (en && reg_hit(a, idx_dir)) begin
            port_write.dir = wbyte;
        end
        if (en && reg_hit(a, idx_data)) begin
            port_write.data = wbyte;
        end
        if (en && reg_hit(a, idx_pup)) begin
            port_write.pup = wbyte;
        end
    endfunction

    // ------------------------------------------------------------
    // Operating mode capture
    // ------------------------------------------------------------
    acio_pkg::op_mode_t mode;
    logic mode_taken;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            mode <= acio_pkg::RST_MODE;
            mode_taken <= 1'b0;
        end else if (!mode_taken) begin
            mode <= acio_pkg::op_mode_t'(mode_pins);
            mode_taken <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // AHB-Lite phases
    // ------------------------------------------------------------
    logic addr_phase;
    logic dp_write;
    logic [31:0] dp_addr;
    logic wr_en;
    logic [7:0] wbyte;

    assign addr_phase = hsel && (htrans == acio_pkg::HTRANS_NONSEQ) && hready;
    assign wr_en = dp_write;
    assign wbyte = hwdata[7:0];

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            dp_write <= 1'b0;
            dp_addr <= 32'h00000000;
        end else if (hready) begin
            dp_write <= addr_phase && hwrite;
            dp_addr <= haddr;
        end
    end

    // Zero wait states; the slave never stalls and never errors.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            hreadyout <= 1'b1;
            hresp <= acio_pkg::HRESP_OKAY;
        end else begin
            hreadyout <= 1'b1;
            hresp <= acio_pkg::HRESP_OKAY;
        end
    end

    // ------------------------------------------------------------
    // Port registers
    // ------------------------------------------------------------
    acio_pkg::port_regs_t regs_b;
    acio_pkg::port_regs_t regs_c;
    acio_pkg::port_regs_t next_regs_b;
    acio_pkg::port_regs_t next_regs_c;
    logic [7:0] stby_ctrl;
    logic [7:0] next_stby_ctrl;
    logic standby_output_hold_enable;

    // Hardware standby clears the port state as power-on reset does.
    always_comb begin
        if (hw_standby) begin
            next_regs_b = acio_pkg::RST_PORT;
            next_regs_c = acio_pkg::RST_PORT;
        end else begin
            next_regs_b = port_write(regs_b, wr_en, dp_addr, wbyte, acio_pkg::IDX_B_DIR,
                acio_pkg::IDX_B_DATA, acio_pkg::IDX_B_PUP);
            next_regs_c = port_write(regs_c, wr_en, dp_addr, wbyte, acio_pkg::IDX_C_DIR,
                acio_pkg::IDX_C_DATA, acio_pkg::IDX_C_PUP);
        end
    end

    always_comb begin
        next_stby_ctrl = stby_ctrl;
        if (wr_en && reg_hit(dp_addr, acio_pkg::IDX_STBY)) begin
            next_stby_ctrl = wbyte;
        end
    end

    assign standby_output_hold_enable = stby_ctrl[acio_pkg::STBY_OPE_BIT];

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            regs_b <= acio_pkg::RST_PORT;
            regs_c <= acio_pkg::RST_PORT;
        end else begin
            regs_b <= next_regs_b;
            regs_c <= next_regs_c;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            stby_ctrl <= acio_pkg::RST_STBY;
        end else begin
            stby_ctrl <= next_stby_ctrl;
        end
    end

    // ------------------------------------------------------------
    // Pin readback
    // ------------------------------------------------------------
    logic [7:0] rb_hold_b;
    logic [7:0] rb_hold_c;
    logic [7:0] rb_b;
    logic [7:0] rb_c;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rb_hold_b <= 8'h00;
            rb_hold_c <= 8'h00;
        end else if (!sw_standby) begin
            rb_hold_b <= readback_calc(regs_b, port_b_in);
            rb_hold_c <= readback_calc(regs_c, port_c_in);
        end
    end

    // Next register values are used so a read right behind a write sees it.
    always_comb begin
        rb_b = sw_standby ? rb_hold_b : readback_calc(next_regs_b, port_b_in);
        rb_c = sw_standby ? rb_hold_c : readback_calc(next_regs_c, port_c_in);
    end

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    logic [7:0] rd_byte;

    always_comb begin
        rd_byte = 8'h00;
        if (reg_hit(haddr, acio_pkg::IDX_B_DIR) || reg_hit(haddr, acio_pkg::IDX_C_DIR)) begin
            rd_byte = acio_pkg::DIR_READ_VALUE;
        end else if (reg_hit(haddr, acio_pkg::IDX_B_DATA)) begin
            rd_byte = next_regs_b.data;
        end else if (reg_hit(haddr, acio_pkg::IDX_B_PIN)) begin
            rd_byte = rb_b;
        end else if (reg_hit(haddr, acio_pkg::IDX_B_PUP)) begin
            rd_byte = next_regs_b.pup;
        end else if (reg_hit(haddr, acio_pkg::IDX_C_DATA)) begin
            rd_byte = next_regs_c.data;
        end else if (reg_hit(haddr, acio_pkg::IDX_C_PIN)) begin
            rd_byte = rb_c;
        end else if (reg_hit(haddr, acio_pkg::IDX_C_PUP)) begin
            rd_byte = next_regs_c.pup;
        end else if (reg_hit(haddr, acio_pkg::IDX_STBY)) begin
            rd_byte = next_stby_ctrl;
        end
    end

    // Read data is fetched in the address phase and stands through the data phase.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            hrdata <= 32'h00000000;
        end else if (addr_phase && !hwrite) begin
            hrdata <= {24'h000000, rd_byte};
        end
    end

    // ------------------------------------------------------------
    // Second port pins
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            port_b_drive <= '0;
        end else begin
            port_b_drive <= drive_calc(mode, regs_b, addr_bus[15:8], port_b_drive,
                hw_standby, sw_standby, standby_output_hold_enable);
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            port_b_pullup <= 8'h00;
        end else if (hw_standby) begin
            port_b_pullup <= 8'h00;
        end else begin
            port_b_pullup <= pullup_calc(mode, regs_b);
        end
    end

    // ------------------------------------------------------------
    // Third port pins
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            port_c_drive <= '0;
        end else begin
            port_c_drive <= drive_calc(mode, regs_c, addr_bus[7:0], port_c_drive,
                hw_standby, sw_standby, standby_output_hold_enable);
        end
    end

    // Pull-ups are registered, so they trail a register write by one cycle.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            port_c_pullup <= 8'h00;
        end else if (hw_standby) begin
            port_c_pullup <= 8'h00;
        end else begin
            port_c_pullup <= pullup_calc(mode, regs_c);
        end
    end

endmodule

// *** core/acio_pkg.sv ***
// Constants and types shared by the address-capable I/O port pair.
package acio_pkg;

    // ------------------------------------------------------------
    // Bus and data widths
    // ------------------------------------------------------------
    localparam int DATA_W = 8;
    localparam int HADDR_W = 32;
    localparam int HDATA_W = 32;
    localparam int ADDR_BUS_W = 16;

    // ------------------------------------------------------------
    // Register indices; byte address is four times the index
    // ------------------------------------------------------------
    localparam logic [15:0] IDX_B_DIR = 16'hFEBA;
    localparam logic [15:0] IDX_B_DATA = 16'hFF6A;
    localparam logic [15:0] IDX_B_PIN = 16'hFF5A;
    localparam logic [15:0] IDX_B_PUP = 16'hFF71;
    localparam logic [15:0] IDX_C_DIR = 16'hFEBB;
    localparam logic [15:0] IDX_C_DATA = 16'hFF6B;
    localparam logic [15:0] IDX_C_PIN = 16'hFF5B;
    localparam logic [15:0] IDX_C_PUP = 16'hFF72;
    localparam logic [15:0] IDX_STBY = 16'hFF80;

    // ------------------------------------------------------------
    // Reset values and field positions
    // ------------------------------------------------------------
    localparam logic [7:0] RST_DIR = 8'h00;
    localparam logic [7:0] RST_DATA = 8'h00;
    localparam logic [7:0] RST_PUP = 8'h00;
    localparam logic [7:0] RST_STBY = 8'h08;
    localparam logic [7:0] DIR_READ_VALUE = 8'hFF;
    localparam int STBY_OPE_BIT = 3;

    // ------------------------------------------------------------
    // Bus encodings
    // ------------------------------------------------------------
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic HRESP_OKAY = 1'b0;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        MODE_0 = 3'b000,
        MODE_1 = 3'b001,
        MODE_2 = 3'b010,
        MODE_3 = 3'b011,
        MODE_4 = 3'b100,
        MODE_5 = 3'b101,
        MODE_6 = 3'b110,
        MODE_7 = 3'b111
    } op_mode_t;

    localparam op_mode_t RST_MODE = MODE_7;

    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe;
    } pin_drive_t;

    typedef struct packed {
        logic [7:0] dir;
        logic [7:0] data;
        logic [7:0] pup;
    } port_regs_t;

    localparam port_regs_t RST_PORT = '{dir: RST_DIR, data: RST_DATA, pup: RST_PUP};

endpackage

// *** testbench/acio_checker.sv ***
// Port-level assertions for the address-capable I/O port pair.
`timescale 1ns/1ps
module acio_checker (
    // Clock, reset and straps
    input logic core_clk,
    input logic rst_n,
    input logic [2:0] mode_pins,
    input logic hw_standby,
    input logic sw_standby,
    input logic [acio_pkg::ADDR_BUS_W-1:0] addr_bus,
    // Register bus
    input logic hsel,
    input logic [acio_pkg::HADDR_W-1:0] haddr,
    input logic [1:0] htrans,
    input logic hwrite,
    input logic hready,
    input logic [acio_pkg::HDATA_W-1:0] hrdata,
    // Pins
    input acio_pkg::pin_drive_t port_b_drive,
    input logic [7:0] port_b_pullup,
    input acio_pkg::pin_drive_t port_c_drive,
    input logic [7:0] port_c_pullup
);
    // ----------------------------------------
    // Helper logic
    // ----------------------------------------
    logic [1:0] age;
    logic [2:0] mode_q;
    logic addr_mode;
    logic live;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            age <= 2'h0;
        end else if (age != 2'h3) begin
            age <= age + 2'h1;
        end
    end
    // The strap is read once, so the checker copies it on the design's edge.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_q <= 3'h7;
        end else if (age == 2'h0) begin
            mode_q <= mode_pins;
        end
    end
    assign addr_mode = (mode_q == 3'h1) || (mode_q == 3'h4) || (mode_q == 3'h5);
    assign live = (age == 2'h3);
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    property p_b_pup_off;
        live && addr_mode |-> port_b_pullup == 8'h00;
    endproperty
    a_b_pup_off: assert property (p_b_pup_off)
        else $error("second port pull-up on in address mode");
    property p_c_pup_off;
        live && addr_mode |-> port_c_pullup == 8'h00;
    endproperty
    a_c_pup_off: assert property (p_c_pup_off)
        else $error("third port pull-up on in address mode");
    property p_b_pup_in;
        (port_b_pullup & port_b_drive.oe) == 8'h00;
    endproperty
    a_b_pup_in: assert property (p_b_pup_in)
        else $error("second port pull-up on a driven pin");
    property p_c_pup_in;
        (port_c_pullup & port_c_drive.oe) == 8'h00;
    endproperty
    a_c_pup_in: assert property (p_c_pup_in)
        else $error("third port pull-up on a driven pin");
    property p_b_all_addr;
        live && addr_mode && !$past(sw_standby) && !$past(hw_standby)
            |-> port_b_drive.oe == 8'hFF && port_b_drive.out == $past(addr_bus[15:8]);
    endproperty
    a_b_all_addr: assert property (p_b_all_addr)
        else $error("second port not following address");
    property p_c_all_addr;
        live && addr_mode && !$past(sw_standby) && !$past(hw_standby)
            |-> port_c_drive.oe == 8'hFF && port_c_drive.out == $past(addr_bus[7:0]);
    endproperty
    a_c_all_addr: assert property (p_c_all_addr)
        else $error("third port not following address");
    property p_sw_hold;
        live && addr_mode && sw_standby && $past(sw_standby) && !$past(hw_standby)
            |-> port_c_drive.oe == 8'h00 || $stable(port_c_drive.out);
    endproperty
    a_sw_hold: assert property (p_sw_hold)
        else $error("address pins moved in software standby");
    property p_hw_clear;
        $past(hw_standby) |-> port_b_drive.oe == 8'h00 && port_c_drive.oe == 8'h00
            && port_b_pullup == 8'h00 && port_c_pullup == 8'h00;
    endproperty
    a_hw_clear: assert property (p_hw_clear)
        else $error("pins active in hardware standby");
    property p_dir_read;
        hsel && hready && htrans == acio_pkg::HTRANS_NONSEQ && !hwrite
            && haddr == {14'h0000, acio_pkg::IDX_C_DIR, 2'b00}
            |=> hrdata == {24'h000000, acio_pkg::DIR_READ_VALUE};
    endproperty
    a_dir_read: assert property (p_dir_read)
        else $error("direction read returned stored bits");
    c_sw_addr: cover property (live && addr_mode && sw_standby);
    c_pup_on: cover property (port_c_pullup != 8'h00);
    c_hw_stby: cover property (hw_standby);
endmodule
bind address_capable_io_port acio_checker u_acio_checker (
    .core_clk(core_clk), .rst_n(rst_n), .mode_pins(mode_pins), .hw_standby(hw_standby),
    .sw_standby(sw_standby), .addr_bus(addr_bus), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
    .port_b_drive(port_b_drive), .port_b_pullup(port_b_pullup),
    .port_c_drive(port_c_drive), .port_c_pullup(port_c_pullup)
);

// *** testbench/ext_pins.sv ***
// Board-side model that resolves the pin levels seen by both ports.
`timescale 1ns/1ps
module ext_pins (
    // Clock
    input logic core_clk,
    // Port drive
    input acio_pkg::pin_drive_t port_b_drive,
    input logic [7:0] port_b_pullup,
    input acio_pkg::pin_drive_t port_c_drive,
    input logic [7:0] port_c_pullup,
    // Board drivers
    input logic [15:0] ext_val,
    input logic [15:0] ext_en,
    // Resolved levels
    output logic [7:0] port_b_in,
    output logic [7:0] port_c_in
);
    logic [15:0] last = 16'h0000;
    // A floating pin without pull-up toggles, so a stale level is never mistaken for a read.
    function automatic logic [7:0] level(acio_pkg::pin_drive_t d, logic [7:0] pu,
                                         logic [7:0] v, logic [7:0] en, logic [7:0] prev);
        return (d.oe & d.out) | (~d.oe & ((en & v) | (~en & (pu | ~prev))));
    endfunction
    assign port_b_in = level(port_b_drive, port_b_pullup, ext_val[15:8], ext_en[15:8], last[15:8]);
    assign port_c_in = level(port_c_drive, port_c_pullup, ext_val[7:0], ext_en[7:0], last[7:0]);
    always @(posedge core_clk) begin
        last <= {port_b_in, port_c_in};
    end
endmodule

// *** testbench/test_address_capable_io_port.sv ***
// Self-checking bench for the address-capable I/O port pair.
`timescale 1ns/1ps
module test_address_capable_io_port;
    logic core_clk, rst_n, hw_standby, sw_standby, hsel, hwrite, hreadyout, hresp;
    logic [2:0] mode_pins, hsize;
    logic [15:0] addr_bus, ext_val, ext_en;
    logic [1:0] htrans;
    logic [31:0] haddr, hwdata, hrdata;
    logic [7:0] port_b_in, port_c_in, port_b_pullup, port_c_pullup, rd, oe;
    acio_pkg::pin_drive_t port_b_drive, port_c_drive;
    int err_count, cmp_count;
    logic am, ad;
    address_capable_io_port u_address_capable_io_port (
        .core_clk(core_clk), .rst_n(rst_n), .mode_pins(mode_pins), .hw_standby(hw_standby),
        .sw_standby(sw_standby), .addr_bus(addr_bus), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .port_b_in(port_b_in),
        .port_b_drive(port_b_drive), .port_b_pullup(port_b_pullup), .port_c_in(port_c_in),
        .port_c_drive(port_c_drive), .port_c_pullup(port_c_pullup)
    );
    ext_pins u_ext_pins (
        .core_clk(core_clk), .port_b_drive(port_b_drive), .port_b_pullup(port_b_pullup),
        .port_c_drive(port_c_drive), .port_c_pullup(port_c_pullup), .ext_val(ext_val),
        .ext_en(ext_en), .port_b_in(port_b_in), .port_c_in(port_c_in)
    );
    // ----------------------------------------
    // Clock, tasks and verdict
    // ----------------------------------------
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    task automatic close_out();
        $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic check(logic [7:0] seen, logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wait_ready();
        do @(posedge core_clk); while (hreadyout !== 1'b1);
    endtask
    task automatic bus_cycle(logic [15:0] idx, logic wr, logic [7:0] d);
        hsel <= 1'b1;
        haddr <= {14'h0000, idx, 2'b00};
        htrans <= acio_pkg::HTRANS_NONSEQ;
        hwrite <= wr;
        hsize <= 3'h2;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h000000, d};
        wait_ready();
        rd = hrdata[7:0];
        check({7'h00, hresp}, 8'h00);
    endtask
    task automatic rd_chk(logic [15:0] idx, logic [7:0] exp);
        bus_cycle(idx, 1'b0, 8'h00);
        check(rd, exp);
    endtask
    task automatic do_reset(logic [2:0] m);
        rst_n <= 1'b0;
        mode_pins <= m;
        repeat (12) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge core_clk);
    endtask
    initial begin
        repeat (40000) @(posedge core_clk);
        err_count++;
        close_out();
    end
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        {rst_n, hw_standby, sw_standby, hsel, hwrite, htrans, haddr, hwdata} = '0;
        {mode_pins, hsize, addr_bus, ext_val, ext_en} = '0;
        err_count = 0;
        cmp_count = 0;
        do_reset(3'h7);
        rd_chk(acio_pkg::IDX_C_DATA, 8'h00);
        rd_chk(acio_pkg::IDX_C_PUP, 8'h00);
        rd_chk(acio_pkg::IDX_B_PUP, 8'h00);
        rd_chk(acio_pkg::IDX_C_DIR, acio_pkg::DIR_READ_VALUE);
        rd_chk(16'h0000, 8'h00);
        rd_chk(acio_pkg::IDX_STBY, acio_pkg::RST_STBY);
        bus_cycle(acio_pkg::IDX_C_DATA, 1'b1, 8'hA5);
        bus_cycle(acio_pkg::IDX_C_DIR, 1'b1, 8'h0F);
        bus_cycle(acio_pkg::IDX_C_PUP, 1'b1, 8'h96);
        rd_chk(acio_pkg::IDX_C_PUP, 8'h96);
        rd_chk(acio_pkg::IDX_C_DATA, 8'hA5);
        rd_chk(acio_pkg::IDX_C_DIR, acio_pkg::DIR_READ_VALUE);
        ext_val <= 16'h003C;
        ext_en <= 16'h00FF;
        repeat (3) @(posedge core_clk);
        rd_chk(acio_pkg::IDX_C_PIN, 8'h35);
        bus_cycle(acio_pkg::IDX_C_PUP, 1'b1, 8'hFF);
        ext_en <= 16'h0000;
        repeat (3) @(posedge core_clk);
        check(port_c_pullup, 8'hF0);
        rd_chk(acio_pkg::IDX_C_PIN, 8'hF5);
        bus_cycle(acio_pkg::IDX_C_PIN, 1'b1, 8'h00);
        rd_chk(acio_pkg::IDX_C_PIN, 8'hF5);
        rd_chk(acio_pkg::IDX_C_DATA, 8'hA5);
        sw_standby <= 1'b1;
        repeat (3) @(posedge core_clk);
        ext_val <= 16'h0000;
        ext_en <= 16'h00FF;
        repeat (3) @(posedge core_clk);
        rd_chk(acio_pkg::IDX_C_PIN, 8'hF5);
        sw_standby <= 1'b0;
        repeat (3) @(posedge core_clk);
        rd_chk(acio_pkg::IDX_C_PIN, 8'h05);
        bus_cycle(acio_pkg::IDX_B_PUP, 1'b1, 8'h3C);
        hw_standby <= 1'b1;
        repeat (3) @(posedge core_clk);
        check(port_c_drive.oe, 8'h00);
        hw_standby <= 1'b0;
        ext_val <= 16'h00A3;
        repeat (3) @(posedge core_clk);
        check(port_c_drive.oe, 8'h00);
        rd_chk(acio_pkg::IDX_C_DATA, 8'h00);
        rd_chk(acio_pkg::IDX_C_PUP, 8'h00);
        rd_chk(acio_pkg::IDX_B_PUP, 8'h00);
        rd_chk(acio_pkg::IDX_C_PIN, 8'hA3);
        ext_en <= 16'h0000;
        for (int m = 0; m < 8; m++) begin
            do_reset(3'(m));
            addr_bus <= 16'h3C5A;
            bus_cycle(acio_pkg::IDX_B_DATA, 1'b1, 8'hA5);
            bus_cycle(acio_pkg::IDX_C_DATA, 1'b1, 8'hA5);
            bus_cycle(acio_pkg::IDX_B_PUP, 1'b1, 8'hFF);
            bus_cycle(acio_pkg::IDX_C_PUP, 1'b1, 8'hFF);
            bus_cycle(acio_pkg::IDX_B_DIR, 1'b1, 8'h0F);
            bus_cycle(acio_pkg::IDX_C_DIR, 1'b1, 8'h0F);
            repeat (3) @(posedge core_clk);
            am = m inside {1, 4, 5};
            ad = am || (m inside {2, 6});
            oe = am ? 8'hFF : 8'h0F;
            check(port_b_drive.oe, oe);
            check(port_c_drive.oe, oe);
            check(port_b_drive.out & oe, (ad ? 8'h3C : 8'hA5) & oe);
            check(port_c_drive.out & oe, (ad ? 8'h5A : 8'hA5) & oe);
            check(port_b_pullup, am ? 8'h00 : 8'hF0);
            check(port_c_pullup, am ? 8'h00 : 8'hF0);
        end
        do_reset(3'h1);
        addr_bus <= 16'h1234;
        repeat (3) @(posedge core_clk);
        sw_standby <= 1'b1;
        repeat (2) @(posedge core_clk);
        addr_bus <= 16'hFFFF;
        repeat (3) @(posedge core_clk);
        check(port_c_drive.out, 8'h34);
        check(port_c_drive.oe, 8'hFF);
        sw_standby <= 1'b0;
        repeat (3) @(posedge core_clk);
        check(port_c_drive.out, 8'hFF);
        bus_cycle(acio_pkg::IDX_STBY, 1'b1, 8'h00);
        sw_standby <= 1'b1;
        repeat (3) @(posedge core_clk);
        check(port_c_drive.oe, 8'h00);
        check(port_b_drive.oe, 8'h00);
        sw_standby <= 1'b0;
        repeat (2) @(posedge core_clk);
        close_out();
    end
endmodule
